/* File: sim/pidib_adc_model.sv */
// ----------------------------------------
// error converter front end
// ----------------------------------------
module pidib_adc_model
  import pidib_pkg::*;
(
  input wire logic clock,
  input wire logic go,
  input wire logic signed [ERR_W-1:0] value,
  output logic update,
  output logic signed [ERR_W-1:0] errorSample
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    update = 1'b0;
    errorSample = '0;
  end

  // sample valid only beside the trigger; scrambled after so a late read shows up
  always @(posedge clock) begin
    update <= go;
    errorSample <= go ? value : ~errorSample;
  end
endmodule // pidib_adc_model

/* File: sim/pidib_integral_branch_test.sv */
module pidib_integral_branch_test
  import pidib_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic sumMode;
    logic [13:0] gain;
    logic [23:0] start;
    logic [8:0] sample;
    logic [23:0] expOut;
  } pidib_row_s;

  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic go = 1'b0;
  logic signed [ERR_W-1:0] val = '0;
  logic update;
  logic signed [ERR_W-1:0] errorSample;
  pidib_bus_s bus = '0;
  logic [DATA_W-1:0] rdata;
  logic signed [ACC_W-1:0] integratorOut;
  logic outValid;
  int err_total = 0;
  int n_tests = 0;
  pidib_row_s rows [6] = '{
    '{1'b0, 14'h0010, 24'h000000, 9'h064, 24'h000640},
    '{1'b1, 14'h0010, 24'h000100, 9'h1e2, 24'h000560},
    '{1'b0, 14'h1fff, 24'h7ff000, 9'h0ff, 24'h7fffff},
    '{1'b1, 14'h2000, 24'h800100, 9'h0ff, 24'h800000},
    '{1'b1, 14'h2000, 24'h000000, 9'h100, 24'h002000},
    '{1'b1, 14'h2000, 24'h000000, 9'h100, 24'h400000}};

  always #50 clock = ~clock;

  pidib_adc_model u_adc (.clock(clock), .go(go), .value(val), .update(update), .errorSample(errorSample));

  pidib_integral_branch u_dut (.clock(clock), .nrst(nrst), .update(update), .errorSample(errorSample),
    .busReq(bus), .rdata(rdata), .integratorOut(integratorOut), .outValid(outValid));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
      err_total++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clock);
    bus.wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clock);
    bus.rd <= 1'b0;
    #1;
    check("rdata", rdata, e);
  endtask

  // n back-to-back triggers; result looked at after the last one lands
  task automatic upd(input logic [8:0] s, input int n);
    @(posedge clock);
    go <= 1'b1;
    val <= s;
    repeat (n) @(posedge clock);
    go <= 1'b0;
    @(posedge clock);
    #1;
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge clock);
    err_total++;
    results();
  end

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    repeat (3) @(posedge clock);
    check("out", {8'h0, integratorOut}, 32'h0);
    rd(OFS_UPPER, 32'h007fffff);
    rd(OFS_LOWER, 32'h00800000);
    rd(OFS_GAIN, 32'h0);
    rd(OFS_CTRL, 32'h0);
    rd(OFS_ACC, 32'h0);
    rd(8'h20, 32'h0);
    for (int i = 0; i < 6; i++) begin
      wr(OFS_CTRL, {30'h0, rows[i].sumMode, 1'b0});
      wr(OFS_GAIN, {18'h0, rows[i].gain});
      // trigger idle around the preload
      wr(OFS_ACC, {8'h0, rows[i].start});
      check("out", {8'h0, integratorOut}, {8'h0, rows[i].start});
      check("valid", {31'h0, outValid}, 32'h1);
      upd(rows[i].sample, 1);
      check("out", {8'h0, integratorOut}, {8'h0, rows[i].expOut});
      check("valid", {31'h0, outValid}, 32'h1);
      rd(OFS_ACC, {8'h0, rows[i].expOut});
    end
    @(posedge clock);
    #1;
    check("rdata", rdata, 32'h0);
    // narrow limits
    wr(OFS_CTRL, 32'h0);
    wr(OFS_GAIN, 32'h10);
    wr(OFS_UPPER, 32'h001000);
    wr(OFS_LOWER, 32'hfff000);
    wr(OFS_ACC, 32'h000f00);
    upd(9'h064, 1);
    check("out", {8'h0, integratorOut}, 32'h001000);
    wr(OFS_ACC, 32'h0);
    upd(9'h100, 1);
    check("out", {8'h0, integratorOut}, 32'hfff000);
    upd(9'h1ff, 1);
    check("out", {8'h0, integratorOut}, 32'hfff000);
    rd(OFS_STATUS, 32'h2);
    // freeze holds accumulator and previous sample
    wr(OFS_ACC, 32'h100);
    wr(OFS_CTRL, 32'h1);
    upd(9'h064, 1);
    check("valid", {31'h0, outValid}, 32'h0);
    check("out", {8'h0, integratorOut}, 32'h100);
    rd(OFS_STATUS, 32'h6);
    wr(OFS_SAMPLE, 32'h55);
    rd(OFS_SAMPLE, 32'h1ff);
    wr(OFS_CTRL, 32'h0);
    upd(9'h064, 1);
    check("out", {8'h0, integratorOut}, 32'h740);
    wr(OFS_GAIN, 32'h1);
    upd(9'h064, 2);
    check("out", {8'h0, integratorOut}, 32'h808);
    results();
  end
endmodule // pidib_integral_branch_test

/* File: src/pidib_integral_branch.sv */
module pidib_integral_branch
  import pidib_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic update,
  input wire logic signed [ERR_W-1:0] errorSample,
  input wire pidib_bus_s busReq,
  output logic [DATA_W-1:0] rdata,
  output logic signed [ACC_W-1:0] integratorOut,
  output logic outValid
);

  // ----------------------------------------
  // reset
  // ----------------------------------------
  logic rstN;

  pidib_reset_sync u_rst (
    .clock(clock),
    .nrst(nrst),
    .rstSyncN(rstN)
  );

  // ----------------------------------------
  // registers
  // ----------------------------------------
  pidib_cfg_s cfg;
  logic signed [ACC_W-1:0] acc;
  logic signed [ERR_W-1:0] prevSample;
  logic signed [ERR_W-1:0] lastSample;
  logic clampedHigh;
  logic clampedLow;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  logic wrCtrl;
  logic wrGain;
  logic wrUpper;
  logic wrLower;
  logic accWr;
  logic signed [ACC_W-1:0] wrAccValue;

  assign wrCtrl = busReq.wr && (busReq.addr == OFS_CTRL);
  assign wrGain = busReq.wr && (busReq.addr == OFS_GAIN);
  assign wrUpper = busReq.wr && (busReq.addr == OFS_UPPER);
  assign wrLower = busReq.wr && (busReq.addr == OFS_LOWER);
  assign accWr = busReq.wr && (busReq.addr == OFS_ACC);
  assign wrAccValue = busReq.wdata[ACC_W-1:0];

  // ----------------------------------------
  // multiplier
  // ----------------------------------------
  logic signed [MULT_W-1:0] presentWide;
  logic signed [MULT_W-1:0] pairSum;
  logic signed [MULT_W-1:0] multiplicand;
  logic signed [ACC_W-1:0] product;

  assign presentWide = {errorSample[ERR_W-1], errorSample};
  assign pairSum = presentWide + {prevSample[ERR_W-1], prevSample};
  assign multiplicand = cfg.sumMode ? pairSum : presentWide;
  // 10-bit by 14-bit signed fits 24 bits exactly, so no guard is needed
  assign product = multiplicand * cfg.gain;

  // ----------------------------------------
  // accumulate, saturate, clamp
  // ----------------------------------------
  logic signed [ACC_W-1:0] satSum;
  logic satHigh;
  logic satLow;
  logic signed [ACC_W-1:0] limited;
  logic hitUpper;
  logic hitLower;
  logic doAccum;
  logic signed [ACC_W-1:0] next_acc;

  pidib_sat_add u_add (
    .acc(acc),
    .addend(product),
    .sum(satSum),
    .satHigh(satHigh),
    .satLow(satLow)
  );

  assign limited = clampLimits(satSum, cfg.upper, cfg.lower);
  assign hitUpper = satHigh || (satSum > cfg.upper);
  assign hitLower = satLow || (satSum < cfg.lower);
  assign doAccum = update && !cfg.freeze;
  // software write beats a colliding update so the preload is never lost
  assign next_acc = accWr ? wrAccValue : doAccum ? limited : acc;

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      cfg.freeze <= 1'b0;
      cfg.sumMode <= 1'b0;
    end else if (wrCtrl) begin
      cfg.freeze <= busReq.wdata[CTRL_FREEZE_BIT];
      cfg.sumMode <= busReq.wdata[CTRL_SUM_BIT];
    end
  end

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      cfg.gain <= GAIN_RESET;
    end else if (wrGain) begin
      cfg.gain <= busReq.wdata[GAIN_W-1:0];
    end
  end

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      cfg.upper <= ACC_MAX;
      cfg.lower <= ACC_MIN;
    end else begin
      cfg.upper <= wrUpper ? busReq.wdata[ACC_W-1:0] : cfg.upper;
      cfg.lower <= wrLower ? busReq.wdata[ACC_W-1:0] : cfg.lower;
    end
  end

  // ----------------------------------------
  // accumulator and output
  // ----------------------------------------
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      acc <= ACC_RESET;
      integratorOut <= ACC_RESET;
      outValid <= 1'b0;
    end else begin
      acc <= next_acc;
      integratorOut <= next_acc;
      outValid <= doAccum || accWr;
    end
  end

  // ----------------------------------------
  // sample history and status
  // ----------------------------------------
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      prevSample <= '0;
      lastSample <= '0;
    end else if (doAccum) begin
      prevSample <= errorSample;
      lastSample <= errorSample;
    end
  end

  // flags describe the latest unfrozen update only
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      clampedHigh <= 1'b0;
      clampedLow <= 1'b0;
    end else if (doAccum) begin
      clampedHigh <= hitUpper;
      clampedLow <= hitLower;
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  logic [DATA_W-1:0] ctrlWord;
  logic [DATA_W-1:0] statusWord;
  logic [DATA_W-1:0] readMux;

  assign ctrlWord = {{(DATA_W-2){1'b0}}, cfg.sumMode, cfg.freeze};
  assign statusWord = {{(DATA_W-3){1'b0}}, cfg.freeze, clampedLow, clampedHigh};

  always_comb begin
    case (busReq.addr)
      OFS_CTRL: readMux = ctrlWord;
      OFS_GAIN: readMux = {{(DATA_W-GAIN_W){1'b0}}, cfg.gain};
      OFS_UPPER: readMux = zeroExtAcc(cfg.upper);
      OFS_LOWER: readMux = zeroExtAcc(cfg.lower);
      OFS_ACC: readMux = zeroExtAcc(acc);
      OFS_STATUS: readMux = statusWord;
      OFS_SAMPLE: readMux = {{(DATA_W-ERR_W){1'b0}}, lastSample};
      default: readMux = '0;
    endcase
  end

  // data stand only in the cycle after the strobe
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      rdata <= '0;
    end else begin
      rdata <= busReq.rd ? readMux : '0;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstN);

  logic signed [ACC_W+GAIN_W:0] refProduct;
  logic signed [ACC_W:0] refSum;

  assign refProduct = multiplicand * cfg.gain;
  assign refSum = acc + product;

  sequence quietUpdate;
    update && !cfg.freeze && !accWr;
  endsequence

  sequence frozenSpan;
    (cfg.freeze && !accWr && !wrCtrl) [*3];
  endsequence

  sequence preloadThenRun;
    accWr ##1 (quietUpdate and !wrCtrl);
  endsequence

  product_fits_a: assert property (
    refProduct == product
  ) else $error("gain product does not fit the accumulator width");

  step_inrange_a: assert property (
    quietUpdate and (refSum <= cfg.upper && refSum >= cfg.lower)
    |=> acc == $past(acc) + $past(product)
  ) else $error("accumulator step differs from previous value plus product");

  no_wrap_a: assert property (
    quietUpdate and (refSum > ACC_MAX) |=> acc == $past(cfg.upper) && acc >= $past(acc)
  ) else $error("positive overflow did not saturate");

  limit_clamp_a: assert property (
    quietUpdate and (cfg.lower <= cfg.upper) |=> acc <= $past(cfg.upper) && acc >= $past(cfg.lower)
  ) else $error("accumulator left the programmed limits");

  out_equals_acc_a: assert property (
    acc >= cfg.lower && acc <= cfg.upper |-> integratorOut == acc
  ) else $error("output differs from accumulator inside limits");

  acc_readback_a: assert property (
    busReq.rd && busReq.addr == OFS_ACC |=> rdata == zeroExtAcc($past(acc))
  ) else $error("accumulator read returned a wrong value");

  write_direct_a: assert property (
    accWr |=> integratorOut == $past(wrAccValue) && outValid
  ) else $error("accumulator write not on the output next cycle");

  freeze_hold_a: assert property (
    frozenSpan |-> $stable(acc) && $stable(prevSample) && !outValid
  ) else $error("frozen integrator changed state");

  freeze_resume_a: assert property (
    cfg.freeze ##1 (!cfg.freeze && !accWr && update)
    |=> acc == clampLimits($past(satSum), $past(cfg.upper), $past(cfg.lower)) && outValid
  ) else $error("integration did not resume from the preserved value");

  update_refresh_a: assert property (
    quietUpdate |=> outValid ##1 !outValid || $past(update) || $past(accWr)
  ) else $error("update did not refresh the output for one cycle");

  preload_start_a: assert property (
    preloadThenRun |=> acc == clampLimits($past(satSum), $past(cfg.upper), $past(cfg.lower))
  ) else $error("preloaded value was not the starting point");

  prev_track_a: assert property (
    quietUpdate |=> prevSample == $past(errorSample) ##1 (update || $stable(prevSample))
  ) else $error("previous sample not captured on update");

endmodule // pidib_integral_branch

/* File: src/pidib_pkg.sv */
package pidib_pkg;

  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int ERR_W = 9;
  localparam int GAIN_W = 14;
  localparam int MULT_W = ERR_W + 1;
  localparam int ACC_W = MULT_W + GAIN_W;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int SYNC_STAGES = 2;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_GAIN = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_UPPER = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_LOWER = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_ACC = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_SAMPLE = 8'h18;

  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int CTRL_FREEZE_BIT = 0;
  localparam int CTRL_SUM_BIT = 1;
  localparam int STAT_HIGH_BIT = 0;
  localparam int STAT_LOW_BIT = 1;
  localparam int STAT_FROZEN_BIT = 2;
  localparam logic signed [GAIN_W-1:0] GAIN_RESET = 14'h0000;
  localparam logic signed [ACC_W-1:0] ACC_MAX = 24'h7fffff;
  localparam logic signed [ACC_W-1:0] ACC_MIN = 24'h800000;
  localparam logic signed [ACC_W-1:0] ACC_RESET = 24'h000000;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } pidib_bus_s;

  typedef struct packed {
    logic freeze;
    logic sumMode;
    logic signed [GAIN_W-1:0] gain;
    logic signed [ACC_W-1:0] upper;
    logic signed [ACC_W-1:0] lower;
  } pidib_cfg_s;

  // upper limit first, so a crossed pair settles on the lower one
  function automatic logic signed [ACC_W-1:0] clampLimits(input logic signed [ACC_W-1:0] v,
                                                          input logic signed [ACC_W-1:0] hi,
                                                          input logic signed [ACC_W-1:0] lo);
    logic signed [ACC_W-1:0] t;
    t = (v > hi) ? hi : v;
    return (t < lo) ? lo : t;
  endfunction

  function automatic logic [DATA_W-1:0] zeroExtAcc(input logic signed [ACC_W-1:0] v);
    return {{(DATA_W-ACC_W){1'b0}}, v};
  endfunction

endpackage

/* File: src/pidib_reset_sync.sv */
module pidib_reset_sync
  import pidib_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  output logic rstSyncN
);

  logic [SYNC_STAGES-1:0] stages;

  // assert at once, release only after two clean edges
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      stages <= '0;
    end else begin
      stages <= {stages[SYNC_STAGES-2:0], 1'b1};
    end
  end

  assign rstSyncN = stages[SYNC_STAGES-1];

endmodule // pidib_reset_sync

/* File: src/pidib_sat_add.sv */
module pidib_sat_add
  import pidib_pkg::*;
(
  input wire logic signed [ACC_W-1:0] acc,
  input wire logic signed [ACC_W-1:0] addend,
  output logic signed [ACC_W-1:0] sum,
  output logic satHigh,
  output logic satLow
);

  // ----------------------------------------
  // one extra bit catches any overflow
  // ----------------------------------------
  logic signed [ACC_W:0] wideSum;

  assign wideSum = {acc[ACC_W-1], acc} + {addend[ACC_W-1], addend};
  assign satHigh = (wideSum[ACC_W:ACC_W-1] == 2'b01);
  assign satLow = (wideSum[ACC_W:ACC_W-1] == 2'b10);
  assign sum = satHigh ? ACC_MAX : satLow ? ACC_MIN : wideSum[ACC_W-1:0];

endmodule // pidib_sat_add
